// >>> hw/sfr_dev.sv
// Flash device end: opcode decode, address, dummy count and data streaming
//
// What this block does
// - Opcode 1Bh: address, two dummy bytes, data.
// - Opcode 0Bh: address, one dummy byte, data.
// - Opcode 03h: address then data, no dummy.
// - Host keeps clock under each opcode limit.
// - Address counter loads, then advances per byte.
// - Data bits leave MSB first, one per clock, two per clock in dual read.
// - Top address wraps to zero without delay.
// - Chip select release ends read, output floats.
// - Dual read: address and one dummy byte.
// - Dual read drives two bits, high first.
// - Dual read end floats both data lines.
// - Security area read: address, two dummies.
// - Protection register read: address, no dummy.
// - Lockdown register read: address, no dummy.
// - Identification read: no address, few bytes.
// - Unknown opcode ignored until next frame.
// - Early release returns to idle, nothing done.
// - Sample rising edge, drive falling, modes 0/3.
// - Address MSB first, top three bits ignored.
`timescale 1ns/100ps
module sfr_dev (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Link
    sfr_link_if.dev link,
    // Array read port, data must follow the address in the same cycle
    output logic [sfr_pkg::ARRAY_ADDR_W-1:0] mem_addr_o,
    output sfr_pkg::sfr_space_t mem_space_o,
    input wire logic [7:0] mem_data_i,
    // Status
    output logic active_o
);
    import sfr_pkg::*;

    typedef enum logic [2:0] {
        DV_IDLE, DV_OPC, DV_ADDR, DV_DUMMY, DV_DATA, DV_IGNORE
    } sfr_dev_state_t;

    typedef struct packed {
        sfr_dev_state_t st;
        logic [1:0] cs_q;
        logic [2:0] sck_q;
        logic [1:0] si_q;
        logic [2:0] cnt;
        logic [1:0] nbytes;
        logic [7:0] sh_in;
        sfr_op_t op;
        logic [23:0] addr;
        logic [7:0] sh_out;
        logic [3:0] left;
        logic so;
        logic so_oe;
        logic shared_second_data_line;
        logic sio_oe;
    } sfr_dev_st_t;

    sfr_dev_st_t r, n;
    logic rise;
    logic fall;
    logic cs_act;
    logic si_b;
    logic [7:0] in_byte;
    logic [7:0] out_byte;
    logic [3:0] out_left;
    sfr_op_t dec;

    // ****************************************
    // Edge detection on synchronised pins
    // ****************************************
    assign rise = r.sck_q[1] && !r.sck_q[2];
    assign fall = !r.sck_q[1] && r.sck_q[2];
    assign cs_act = !r.cs_q[1];
    assign si_b = r.si_q[1];
    assign in_byte = {r.sh_in[6:0], si_b};
    assign dec = sfr_decode(in_byte);
    // First bit of a byte comes straight from the array port
    assign out_byte = (r.left == 4'h0) ? mem_data_i : r.sh_out;
    assign out_left = (r.left == 4'h0) ? BYTE_BITS : r.left;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        n = r;
        n.cs_q = {r.cs_q[0], link.cs_n};
        n.sck_q = {r.sck_q[1:0], link.sck};
        n.si_q = {r.si_q[0], link.si_line};
        if (!cs_act) begin
            // Release ends any frame, lines float
            n.st = DV_IDLE;
            n.so_oe = 1'b0;
            n.sio_oe = 1'b0;
        end else begin
            unique case (r.st)
                DV_IDLE: begin
                    n.st = DV_OPC;
                    n.cnt = 3'h0;
                    n.left = 4'h0;
                end
                DV_OPC: begin
                    if (rise) begin
                        n.sh_in = in_byte;
                        n.cnt = r.cnt + 3'h1;
                        if (r.cnt == 3'h7) begin
                            n.op = dec;
                            n.nbytes = ADDR_BYTES;
                            if (!dec.known || !dec.rd) begin
                                // Unknown or non-read framing: wait for release
                                n.st = DV_IGNORE;
                            end else if (dec.has_addr) begin
                                n.st = DV_ADDR;
                            end else begin
                                n.addr = 24'h0;
                                n.st = DV_DATA;
                            end
                        end
                    end
                end
                DV_ADDR: begin
                    if (rise) begin
                        // MSB first shift of the 24-bit address
                        n.addr = {r.addr[22:0], si_b};
                        n.cnt = r.cnt + 3'h1;
                        if (r.cnt == 3'h7) begin
                            n.nbytes = r.nbytes - 2'h1;
                            if (r.nbytes == 2'h1) begin
                                n.nbytes = r.op.dummy;
                                // Dummy count per opcode
                                n.st = (r.op.dummy != 2'h0) ? DV_DUMMY : DV_DATA;
                            end
                        end
                    end
                end
                DV_DUMMY: begin
                    if (rise) begin
                        // Dummy bits only counted, value dropped
                        n.cnt = r.cnt + 3'h1;
                        if (r.cnt == 3'h7) begin
                            n.nbytes = r.nbytes - 2'h1;
                            if (r.nbytes == 2'h1) begin
                                n.st = DV_DATA;
                            end
                        end
                    end
                end
                DV_DATA: begin
                    if (fall) begin
                        n.so = out_byte[7];
                        n.so_oe = 1'b1;
                        if (r.left == 4'h0) begin
                            // Byte fetched, counter moves on, wraps at top
                            n.addr = {3'h0, r.addr[ARRAY_ADDR_W-1:0] + 21'h1};
                        end
                        if (r.op.dual) begin
                            n.shared_second_data_line = out_byte[6];
                            n.sio_oe = 1'b1;
                            n.sh_out = {out_byte[5:0], 2'h0};
                            n.left = out_left - 4'h2;
                        end else begin
                            n.sh_out = {out_byte[6:0], 1'h0};
                            n.left = out_left - 4'h1;
                        end
                    end
                end
                // Ignored frame ends only at chip select release
                DV_IGNORE: begin
                    n.st = DV_IGNORE;
                end
                default: begin
                    // Illegal state code: drop back to idle
                    n.st = DV_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            r <= '{st: DV_IDLE, cs_q: 2'h3, sck_q: 3'h0, si_q: 2'h3, cnt: 3'h0,
                   nbytes: 2'h0, sh_in: 8'h0, op: '0, addr: 24'h0, sh_out: 8'h0,
                   left: 4'h0, so: 1'b0, so_oe: 1'b0, shared_second_data_line: 1'b0, sio_oe: 1'b0};
        end else begin
            r <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign link.so_d = r.so;
    assign link.so_d_oe = r.so_oe;
    assign link.si_d = r.shared_second_data_line;
    assign link.si_d_oe = r.sio_oe;
    // Array port follows the address counter
    assign mem_addr_o = r.addr[ARRAY_ADDR_W-1:0];
    assign mem_space_o = r.op.space;
    assign active_o = (r.st != DV_IDLE);
endmodule : sfr_dev

// >>> hw/sfr_pkg.sv
// Shared constants, types and opcode decode for the serial flash read path
package sfr_pkg;

    // ****************************************
    // Opcodes
    // ****************************************
    localparam logic [7:0] OP_RD_HI = 8'h1b;
    localparam logic [7:0] OP_RD_FAST = 8'h0b;
    localparam logic [7:0] OP_RD_SLOW = 8'h03;
    localparam logic [7:0] OP_RD_DUAL = 8'h3b;
    localparam logic [7:0] OP_RD_OTP = 8'h77;
    localparam logic [7:0] OP_RD_PROT = 8'h3c;
    localparam logic [7:0] OP_RD_LOCK = 8'h35;
    localparam logic [7:0] OP_RD_ID = 8'h9f;
    localparam logic [7:0] OP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_ERASE_B = 8'hc7;

    // ****************************************
    // Framing and timing
    // ****************************************
    localparam int ARRAY_ADDR_W = 21;
    localparam logic [1:0] ADDR_BYTES = 2'h3;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [7:0] HEAD_OP_BITS = 8'h08;
    localparam logic [7:0] HEAD_ADDR_BITS = 8'h18;
    localparam int CLK_NS = 50;
    localparam int LINK_HALF_NS = 400;
    localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int FIFO_W = 8;
    localparam int FIFO_D = 16;

    // ****************************************
    // Decoded opcode
    // ****************************************
    typedef enum logic [2:0] {SP_ARRAY, SP_OTP, SP_PROT, SP_LOCK, SP_ID} sfr_space_t;

    typedef struct packed {
        logic known;
        logic rd;
        logic has_addr;
        logic [1:0] dummy;
        logic dual;
        sfr_space_t space;
    } sfr_op_t;

    // Opcode to framing: address, dummy count, width, data space
    function automatic sfr_op_t sfr_decode(input logic [7:0] op);
        sfr_op_t d;
        d = '{known: 1'b1, rd: 1'b1, has_addr: 1'b1, dummy: 2'h0, dual: 1'b0, space: SP_ARRAY};
        unique case (op)
            OP_RD_HI: d.dummy = 2'h2;
            OP_RD_FAST: d.dummy = 2'h1;
            OP_RD_SLOW: d.dummy = 2'h0;
            OP_RD_DUAL: begin
                d.dummy = 2'h1;
                d.dual = 1'b1;
            end
            OP_RD_OTP: begin
                d.dummy = 2'h2;
                d.space = SP_OTP;
            end
            OP_RD_PROT: d.space = SP_PROT;
            OP_RD_LOCK: d.space = SP_LOCK;
            OP_RD_ID: begin
                d.has_addr = 1'b0;
                d.space = SP_ID;
            end
            OP_ERASE_A, OP_ERASE_B: begin
                d.rd = 1'b0;
                d.has_addr = 1'b0;
            end
            8'h20, 8'h52, 8'hd8, 8'h02, 8'ha2, 8'h36, 8'h39, 8'h33, 8'h34, 8'h9b: begin
                d.rd = 1'b0;
            end
            8'hb0, 8'hd0, 8'h06, 8'h04, 8'h05, 8'h01, 8'h31, 8'hf0, 8'hb9, 8'hab: begin
                d.rd = 1'b0;
                d.has_addr = 1'b0;
            end
            default: d.known = 1'b0;
        endcase
        return d;
    endfunction : sfr_decode

endpackage : sfr_pkg

// >>> hw/sfr_link_if.sv
// Serial link between host master and flash device, with line resolution
`timescale 1ns/100ps
interface sfr_link_if;
    logic cs_n;
    logic sck;
    logic si_h;
    logic si_h_oe;
    logic si_d;
    logic si_d_oe;
    logic so_d;
    logic so_d_oe;
    logic si_line;
    logic so_line;

    // Resolved line levels, pulled high when nobody drives
    assign si_line = si_h_oe ? si_h : (si_d_oe ? si_d : 1'b1);
    assign so_line = so_d_oe ? so_d : 1'b1;

    modport dev (input cs_n, input sck, input si_line, output si_d, output si_d_oe,
                 output so_d, output so_d_oe);
    modport host (output cs_n, output sck, output si_h, output si_h_oe,
                  input so_line, input si_line);
endinterface : sfr_link_if

// >>> hw/sfr_fifo.sv
// Parameterised valid/ready FIFO for read data
`timescale 1ns/100ps
module sfr_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } sfr_fifo_st_t;

    sfr_fifo_st_t r, n;
    logic [W-1:0] mem [D];
    logic full;
    logic empty;
    logic push;
    logic pop;

    // Flags from pointer comparison
    assign empty = (r.wp == r.rp);
    assign full = (r.wp[AW-1:0] == r.rp[AW-1:0]) && (r.wp[AW] != r.rp[AW]);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[r.rp[AW-1:0]];
    assign push = in_valid_i && !full;
    assign pop = out_ready_i && !empty;

    // Pointer update
    always_comb begin
        n = r;
        if (push) begin
            n.wp = r.wp + 1'b1;
        end
        if (pop) begin
            n.rp = r.rp + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // Storage write
    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[r.wp[AW-1:0]] <= in_data_i;
        end
    end
endmodule : sfr_fifo

// >>> hw/sfr_host.sv
// Host master end: issues read commands and collects data into a FIFO
`timescale 1ns/100ps
module sfr_host #(
    parameter int HALF_CYC = sfr_pkg::LINK_HALF_CYC
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Command port
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic [7:0] cmd_op_i,
    input wire logic [23:0] cmd_addr_i,
    input wire logic [15:0] cmd_len_i,
    // Read data stream
    output logic rd_valid_o,
    input wire logic rd_ready_i,
    output logic [7:0] rd_data_o,
    // Link
    sfr_link_if.host link
);
    import sfr_pkg::*;

    typedef enum logic [1:0] {HS_IDLE, HS_HEAD, HS_READ, HS_GAP} sfr_host_state_t;

    typedef struct packed {
        sfr_host_state_t st;
        logic [7:0] div;
        logic sck;
        logic cs_n;
        logic si;
        logic si_oe;
        logic [47:0] sh;
        logic [7:0] hbits;
        logic [15:0] len;
        logic [7:0] rbyte;
        logic [3:0] rbits;
        logic dual;
        logic [1:0] so_q;
        logic [1:0] sio_q;
        logic push;
        logic [7:0] pdata;
    } sfr_host_st_t;

    sfr_host_st_t r, n;
    sfr_op_t dec;
    logic tick;
    logic fifo_ready;
    logic stall;

    assign dec = sfr_decode(cmd_op_i);
    // Link clock half period from the system clock, well below every limit
    assign tick = (r.div == 8'(HALF_CYC - 1));
    assign stall = (r.st == HS_READ) && !r.sck && (r.rbits == 4'h0) && !fifo_ready;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        n = r;
        n.so_q = {r.so_q[0], link.so_line};
        n.sio_q = {r.sio_q[0], link.si_line};
        n.push = 1'b0;
        if (r.st != HS_IDLE && !stall) begin
            n.div = tick ? 8'h0 : r.div + 8'h1;
        end
        unique case (r.st)
            HS_IDLE: begin
                n.cs_n = 1'b1;
                n.sck = 1'b0;
                n.si_oe = 1'b1;
                if (cmd_valid_i) begin
                    n.cs_n = 1'b0;
                    n.div = 8'h0;
                    n.dual = dec.dual;
                    // Unknown or non-read opcode: no data phase
                    n.len = (dec.known && dec.rd) ? cmd_len_i : 16'h0;
                    // Header: opcode, address bytes, dummy bytes
                    n.hbits = HEAD_OP_BITS + (dec.has_addr ? HEAD_ADDR_BITS : 8'h0)
                        + {3'h0, dec.dummy, 3'h0};
                    n.sh = dec.has_addr ? {cmd_op_i, cmd_addr_i, 16'h0} : {cmd_op_i, 40'h0};
                    n.si = cmd_op_i[7];
                    n.rbits = 4'h0;
                    n.st = HS_HEAD;
                end
            end
            HS_HEAD: begin
                if (tick) begin
                    n.sck = !r.sck;
                    if (!r.sck) begin
                        n.hbits = r.hbits - 8'h1;
                    end else if (r.hbits == 8'h0) begin
                        // Dual data: release the shared line
                        n.si_oe = !r.dual;
                        n.st = (r.len == 16'h0) ? HS_GAP : HS_READ;
                    end else begin
                        n.sh = {r.sh[46:0], 1'b0};
                        n.si = r.sh[46];
                    end
                end
            end
            HS_READ: begin
                if (tick) begin
                    n.sck = !r.sck;
                    if (!r.sck) begin
                        // Sample on the rising edge
                        if (r.dual) begin
                            n.rbyte = {r.rbyte[5:0], r.so_q[1], r.sio_q[1]};
                            n.rbits = r.rbits + 4'h2;
                        end else begin
                            n.rbyte = {r.rbyte[6:0], r.so_q[1]};
                            n.rbits = r.rbits + 4'h1;
                        end
                        if (n.rbits == BYTE_BITS) begin
                            n.push = 1'b1;
                            n.pdata = n.rbyte;
                            n.rbits = 4'h0;
                            n.len = r.len - 16'h1;
                        end
                    end else if (r.len == 16'h0) begin
                        n.st = HS_GAP;
                    end
                end
            end
            HS_GAP: begin
                n.cs_n = 1'b1;
                // Retake the shared line only once the device has let go
                if (tick) begin
                    n.si_oe = 1'b1;
                    n.st = HS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            r <= '{st: HS_IDLE, div: 8'h0, sck: 1'b0, cs_n: 1'b1, si: 1'b0, si_oe: 1'b1,
                   sh: 48'h0, hbits: 8'h0, len: 16'h0, rbyte: 8'h0, rbits: 4'h0,
                   dual: 1'b0, so_q: 2'h3, sio_q: 2'h3, push: 1'b0, pdata: 8'h0};
        end else begin
            r <= n;
        end
    end

    // ****************************************
    // Read data buffer
    // ****************************************
    sfr_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .in_valid_i(r.push),
        .in_ready_o(fifo_ready),
        .in_data_i(r.pdata),
        .out_valid_o(rd_valid_o),
        .out_ready_i(rd_ready_i),
        .out_data_o(rd_data_o)
    );

    assign cmd_ready_o = (r.st == HS_IDLE);
    assign link.cs_n = r.cs_n;
    assign link.sck = r.sck;
    assign link.si_h = r.si;
    assign link.si_h_oe = r.si_oe;
endmodule : sfr_host

// >>> tb/sfr_link_monitor.sv
// Link checker for the serial flash read path
`timescale 1ns/100ps
module sfr_link_monitor (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Link lines
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si_h,
    input wire logic si_h_oe,
    input wire logic si_d,
    input wire logic si_d_oe,
    input wire logic so_d,
    input wire logic so_d_oe
);
    // ********
    // Assertions
    // ********
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    a_so_float_idle: assert property (cs_n [*6] |-> !so_d_oe)
        else $error("serial out driven outside a frame");
    a_sio_float_idle: assert property (cs_n [*6] |-> !si_d_oe)
        else $error("second line driven outside a frame");
    a_line_no_clash: assert property (!(si_h_oe && si_d_oe))
        else $error("both ends drive the shared line");
    a_sio_in_frame: assert property ($rose(si_d_oe) |-> !cs_n && !si_h_oe)
        else $error("second line taken outside dual data");
    a_so_in_frame: assert property ($rose(so_d_oe) |-> !cs_n)
        else $error("serial out enabled without select");
    a_so_on_fall: assert property ($changed(so_d) && so_d_oe && $past(so_d_oe) |->
        !$past(sck, 3))
        else $error("serial out changed away from falling clock");
    a_sio_on_fall: assert property ($changed(si_d) && si_d_oe && $past(si_d_oe) |->
        !$past(sck, 3))
        else $error("second line changed away from falling clock");
    a_sck_in_frame: assert property ($rose(sck) |-> !cs_n)
        else $error("link clock rose outside a frame");
    a_si_on_low: assert property ($changed(si_h) && si_h_oe && $past(si_h_oe) |-> !sck)
        else $error("host data changed while clock high");
    a_sck_high_half: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
        else $error("link clock high phase wrong length");
    // Main scenarios reached
    c_dual: cover property ($rose(si_d_oe));
    c_single: cover property ($rose(so_d_oe));
    c_frame_end: cover property ($rose(cs_n));
endmodule : sfr_link_monitor

// >>> tb/serial_flash_read_path_bench.sv
// Bench joining host and device ends with a byte model of the read stream
`timescale 1ns/100ps
module serial_flash_read_path_bench;
    import sfr_pkg::*;
    // ********
    // Signals
    // ********
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    logic [7:0] cmd_op = 8'h00;
    logic [23:0] cmd_addr = 24'h000000;
    logic [15:0] cmd_len = 16'h0001;
    logic rd_valid;
    logic rd_ready = 1'b0;
    logic [7:0] rd_data;
    logic [ARRAY_ADDR_W-1:0] mem_addr;
    sfr_space_t mem_space;
    logic [7:0] mem_data;
    logic active;
    logic stall = 1'b0;
    logic so_seen = 1'b0;
    int num_errors = 0;
    int n_checks = 0;
    integer seed = 32'h8c75fe6f;
    logic [7:0] exp_q[$];
    logic [7:0] ops [8] = '{OP_RD_HI, OP_RD_FAST, OP_RD_SLOW, OP_RD_DUAL, OP_RD_OTP,
                            OP_RD_PROT, OP_RD_LOCK, OP_RD_ID};
    sfr_link_if lk ();
    // Memory contents, an 8-bit sum of space and address bits (values can repeat)
    function automatic logic [7:0] mem_val(input sfr_space_t sp, input logic [20:0] a);
        return a[7:0] + a[20:13] + {sp, 5'h00};
    endfunction : mem_val
    // ********
    // Instances
    // ********
    sfr_dev i_sfr_dev (.clk_sys_i, .rst_i, .link(lk), .mem_addr_o(mem_addr),
        .mem_space_o(mem_space), .mem_data_i(mem_data), .active_o(active));
    sfr_host i_sfr_host (.clk_sys_i, .rst_i, .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
        .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_len_i(cmd_len), .rd_valid_o(rd_valid),
        .rd_ready_i(rd_ready), .rd_data_o(rd_data), .link(lk));
    sfr_link_monitor i_sfr_link_monitor (.clk_sys_i, .rst_i, .cs_n(lk.cs_n), .sck(lk.sck),
        .si_h(lk.si_h), .si_h_oe(lk.si_h_oe), .si_d(lk.si_d), .si_d_oe(lk.si_d_oe),
        .so_d(lk.so_d), .so_d_oe(lk.so_d_oe));
    // Clock, memory and random drain
    always #25 clk_sys_i = ~clk_sys_i;
    assign mem_data = mem_val(mem_space, mem_addr);
    always @(negedge clk_sys_i) rd_ready <= !stall && ($random(seed) % 2 != 0);
    always @(posedge clk_sys_i) if (lk.so_d_oe || lk.si_d_oe) so_seen <= 1'b1;
    // Compare every drained byte with the model
    always @(posedge clk_sys_i) begin
        if (!rst_i && rd_valid && rd_ready) begin
            if (exp_q.size() == 0) chk("surplus byte", 8'h00, 8'h01);
            else chk("read byte", exp_q.pop_front(), rd_data);
        end
    end
    // ********
    // Tasks
    // ********
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    // One command; hold keeps the drain stalled for that many cycles
    task automatic run_cmd(input logic [7:0] op, input logic [23:0] a, input int n,
                           input logic rd, input int hold);
        sfr_space_t sp;
        logic [20:0] p;
        int k;
        sp = op == OP_RD_OTP ? SP_OTP : op == OP_RD_PROT ? SP_PROT : op == OP_RD_LOCK ?
             SP_LOCK : op == OP_RD_ID ? SP_ID : SP_ARRAY;
        p = op == OP_RD_ID ? 21'h000000 : a[20:0];
        if (rd) for (k = 0; k < n; k++) exp_q.push_back(mem_val(sp, p + 21'(k)));
        @(negedge clk_sys_i);
        so_seen = 1'b0;
        stall = hold > 0;
        cmd_op = op;
        cmd_addr = a;
        cmd_len = 16'(n);
        cmd_valid = 1'b1;
        @(negedge clk_sys_i);
        cmd_valid = 1'b0;
        k = 0;
        do begin
            @(negedge clk_sys_i);
            k++;
            if (k == hold) begin
                chk("held byte", 8'h01, {7'h00, rd_valid});
                stall = 1'b0;
            end
        end while ((!cmd_ready || exp_q.size() != 0) && k < 20000);
        chk("command timeout", 8'h00, {7'h00, k >= 20000});
        chk("device idle after end", 8'h00, {7'h00, active});
        chk("bytes left", 8'h00, 8'(exp_q.size()));
        chk("out drive after end", 8'h00, {7'h00, lk.so_d_oe});
        chk("second drive after end", 8'h00, {7'h00, lk.si_d_oe});
        if (!rd) chk("drive on ignored op", 8'h00, {7'h00, so_seen});
    endtask : run_cmd
    // ********
    // Sequence
    // ********
    initial begin
        repeat (4) @(negedge clk_sys_i);
        rst_i = 1'b0;
        foreach (ops[i]) run_cmd(ops[i], 24'($random(seed)), 2 + i % 4, 1'b1, 0);
        run_cmd(OP_RD_HI, 24'hfffffe, 4, 1'b1, 0);
        run_cmd(OP_RD_DUAL, 24'h1ffffd, 5, 1'b1, 0);
        run_cmd(OP_RD_SLOW, 24'($random(seed)), 20, 1'b1, 4000);
        run_cmd(OP_ERASE_A, 24'h000000, 2, 1'b0, 0);
        run_cmd(OP_ERASE_B, 24'h000000, 2, 1'b0, 0);
        run_cmd(8'hff, 24'h000000, 2, 1'b0, 0);
        run_cmd(OP_RD_FAST, 24'($random(seed)), 3, 1'b1, 0);
        tally_and_finish();
    end
    // Watchdog against a hung link
    initial begin
        #3ms;
        num_errors++;
        tally_and_finish();
    end
endmodule : serial_flash_read_path_bench
